// ===== hdl/dscg_clock_gen.sv
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module dscg_clock_gen
  import dscg_pkg::*;
#(
  parameter int WDT_RESET_MC = 96
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        i_rst_pin,
  input  wire logic        i_watchdog_timeout,
  input  wire logic        i_external_fetch_select,
  input  wire logic        i_security_level1,
  input  wire logic [15:0] i_fetch_addr,
  input  wire logic        i_data_access,
  output logic             o_rst_pin_o,
  output logic             o_rst_pin_oe,
  output logic             o_internal_reset,
  output logic             o_osc_tick,
  output logic             o_core_clk,
  output logic             o_machine_cycle_tick,
  output logic             o_ale,
  output logic             o_program_fetch_strobe_n,
  output logic             o_fetch_external
);

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  dscg_ahb_req_type req_reg;
  dscg_ahb_req_type req_next;
  logic             mode_bit_reg;
  logic             ale_disable_reg;
  logic [31:0]      rdata_reg;
  logic [31:0]      rdata_next;
  logic             addr_aligned;
  logic             wr_clock_control;
  logic             wr_aux_control;

  assign addr_aligned = (haddr[BYTE_SHIFT-1:0] == 2'h0)
                        && (haddr[31:ADDR_W] == '0);
  assign req_next.sel   = hsel && hready && (htrans == HTRANS_NONSEQ) && addr_aligned;
  assign req_next.write = hwrite;
  assign req_next.idx   = haddr[BYTE_SHIFT+7:BYTE_SHIFT];
  assign wr_clock_control = req_reg.sel && req_reg.write && (req_reg.idx == CLOCK_CONTROL_IDX);
  assign wr_aux_control   = req_reg.sel && req_reg.write && (req_reg.idx == AUX_CONTROL_IDX);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      req_reg <= '0;
    end else begin
      req_reg <= req_next;
    end
  end

  // ----------------------------------------------------------------
  // reset pin and watchdog
  // ----------------------------------------------------------------
  dscg_rst_state_type rst_state_reg;
  dscg_rst_state_type rst_state_next;
  logic [1:0]         pin_mc_reg;
  logic [1:0]         pin_mc_next;
  logic [7:0]         wdt_mc_reg;
  logic [7:0]         wdt_mc_next;
  logic               mc_tick;
  logic               pin_done;
  logic               wdt_done;
  logic               block_rst;

  // the pin counts only whole cycles: the first boundary starts the count
  assign pin_done = mc_tick && i_rst_pin && (pin_mc_reg == RST_PIN_MC);
  assign wdt_done = mc_tick && (wdt_mc_reg == 8'(WDT_RESET_MC - 1));

  always_comb begin
    rst_state_next = rst_state_reg;
    pin_mc_next    = pin_mc_reg;
    wdt_mc_next    = wdt_mc_reg;
    case (rst_state_reg)
      RST_IDLE: begin
        if (i_watchdog_timeout) begin
          rst_state_next = RST_WDT;
          wdt_mc_next    = 8'h00;
        end else if (!i_rst_pin) begin
          pin_mc_next = 2'h0;
        end else if (pin_done) begin
          rst_state_next = RST_PIN;
        end else if (mc_tick) begin
          pin_mc_next = pin_mc_reg + 2'h1;
        end
      end
      RST_PIN: begin
        if (!i_rst_pin) begin
          rst_state_next = RST_IDLE;
          pin_mc_next    = 2'h0;
        end
      end
      RST_WDT: begin
        // pin is driven by us here, so its input level is ignored
        if (wdt_done) begin
          rst_state_next = RST_IDLE;
          pin_mc_next    = 2'h0;
        end else if (mc_tick) begin
          wdt_mc_next = wdt_mc_reg + 8'h01;
        end
      end
      default: begin
        rst_state_next = RST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rst_state_reg <= RST_IDLE;
      pin_mc_reg    <= 2'h0;
      wdt_mc_reg    <= 8'h00;
    end else begin
      rst_state_reg <= rst_state_next;
      pin_mc_reg    <= pin_mc_next;
      wdt_mc_reg    <= wdt_mc_next;
    end
  end

  assign o_internal_reset = (rst_state_reg != RST_IDLE);
  assign o_rst_pin_oe     = (rst_state_reg == RST_WDT);
  assign o_rst_pin_o      = (rst_state_reg == RST_WDT);
  assign block_rst        = i_rst || o_internal_reset;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (block_rst) begin
      mode_bit_reg    <= MODE_RESET_VALUE;
      ale_disable_reg <= ALE_DIS_RESET_VALUE;
    end else begin
      if (wr_clock_control) begin
        mode_bit_reg <= hwdata[DOUBLE_SPEED_BIT];
      end
      if (wr_aux_control) begin
        ale_disable_reg <= hwdata[ALE_DISABLE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // divider and glitch-free mode switch
  // ----------------------------------------------------------------
  logic div_reg;
  logic mode_active_reg;
  logic div_rise;

  // crystal period equals one i_sys_clk period
  assign div_rise = !div_reg;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      div_reg         <= 1'b0;
      mode_active_reg <= MODE_RESET_VALUE;
    end else begin
      div_reg <= !div_reg;
      if (div_rise) begin
        mode_active_reg <= mode_bit_reg;
      end
    end
  end

  // bypass passes every crystal period, divider every other one
  assign o_osc_tick = mode_active_reg ? 1'b1 : div_reg;
  assign o_core_clk = mode_active_reg ? 1'b1 : div_reg;

  // ----------------------------------------------------------------
  // phase generator and strobes
  // ----------------------------------------------------------------
  logic [2:0] phase_reg;
  logic       data_cycle_reg;
  logic       ale_reg;
  logic       fetch_strobe_n_reg;
  logic       fetch_sel_latch_reg;
  logic       fetch_sel_eff;
  logic       fetch_ext;
  logic       ale_slot;
  logic       fetch_slot;
  logic       ale_next;
  logic       fetch_strobe_n_next;

  assign mc_tick = o_osc_tick && (phase_reg == PHASE_LAST);
  assign o_machine_cycle_tick = mc_tick;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      phase_reg      <= 3'h0;
      data_cycle_reg <= 1'b0;
    end else if (o_osc_tick) begin
      phase_reg <= (phase_reg == PHASE_LAST) ? 3'h0 : phase_reg + 3'h1;
      if (phase_reg == PHASE_LAST) begin
        data_cycle_reg <= i_data_access;
      end
    end
  end

  // strap caught while in reset, never outside it
  always_ff @(posedge i_sys_clk) begin
    if (block_rst) begin
      fetch_sel_latch_reg <= i_external_fetch_select;
    end
  end

  assign fetch_sel_eff = i_security_level1 ? fetch_sel_latch_reg
                                           : i_external_fetch_select;
  assign fetch_ext = !fetch_sel_eff || (i_fetch_addr > INTERNAL_CODE_LIMIT);
  assign o_fetch_external = fetch_ext;

  assign ale_slot  = (phase_reg == ALE_PHASE_A)
                     || ((phase_reg == ALE_PHASE_B) && !data_cycle_reg);
  assign fetch_slot = ((phase_reg == STROBE_PHASE_A) || (phase_reg == STROBE_PHASE_B))
                      && !data_cycle_reg;
  assign ale_next    = ale_slot && !(ale_disable_reg && !fetch_ext && !data_cycle_reg);
  assign fetch_strobe_n_next = !(fetch_slot && fetch_ext);

  always_ff @(posedge i_sys_clk) begin
    if (block_rst) begin
      ale_reg            <= 1'b0;
      fetch_strobe_n_reg <= 1'b1;
    end else begin
      ale_reg            <= ale_next;
      fetch_strobe_n_reg <= fetch_strobe_n_next;
    end
  end

  assign o_ale                    = ale_reg;
  assign o_program_fetch_strobe_n = fetch_strobe_n_reg;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (req_next.sel && !req_next.write) begin
      case (req_next.idx)
        CLOCK_CONTROL_IDX: rdata_next[DOUBLE_SPEED_BIT] = mode_bit_reg;
        AUX_CONTROL_IDX:   rdata_next[ALE_DISABLE_BIT]  = ale_disable_reg;
        CLOCK_STATUS_IDX: begin
          rdata_next[ST_MODE_BIT]      = mode_active_reg;
          rdata_next[ST_FETCH_SEL_BIT] = fetch_sel_eff;
          rdata_next[ST_RESET_BIT]     = o_internal_reset;
          rdata_next[ST_WDT_DRIVE_BIT] = o_rst_pin_oe;
        end
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [3:0] xtal_cnt_reg;
  logic       mode_moved_reg;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      xtal_cnt_reg   <= 4'h0;
      mode_moved_reg <= 1'b0;
    end else if (mc_tick) begin
      // a switch pending at the boundary lands in the next cycle
      xtal_cnt_reg   <= 4'h0;
      mode_moved_reg <= (mode_active_reg != mode_bit_reg);
    end else begin
      xtal_cnt_reg   <= xtal_cnt_reg + 4'h1;
      mode_moved_reg <= mode_moved_reg || (mode_active_reg != mode_bit_reg);
    end
  end

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_pin_held;
    (rst_state_reg == RST_IDLE) && pin_done && !i_watchdog_timeout;
  endsequence

  property p_pin_reset;
    s_pin_held |=> o_internal_reset [*2];
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin reset not taken");
  property p_wdt_drive;
    (rst_state_reg == RST_IDLE) && i_watchdog_timeout |=> o_rst_pin_oe && o_rst_pin_o
      && o_internal_reset;
  endproperty
  a_wdt_drive: assert property (p_wdt_drive) else $error("reset pin not driven");
  // an internal reset starting right after the boundary swallows the strobe
  property p_ale_phase;
    mc_tick && !block_rst ##1 !block_rst |=> o_ale || $past(ale_disable_reg);
  endproperty
  a_ale_phase: assert property (p_ale_phase) else $error("ale missing at phase 0");
  property p_ale_skip;
    data_cycle_reg && (phase_reg == ALE_PHASE_B) && !block_rst |=> !o_ale;
  endproperty
  a_ale_skip: assert property (p_ale_skip) else $error("ale not skipped");
  property p_ale_mute;
    ale_disable_reg && !fetch_ext && !data_cycle_reg |=> !o_ale;
  endproperty
  a_ale_mute: assert property (p_ale_mute) else $error("ale during internal fetch");
  property p_fetch_strobe_skip;
    data_cycle_reg |=> o_program_fetch_strobe_n;
  endproperty
  a_fetch_strobe_skip: assert property (p_fetch_strobe_skip) else $error("strobe in data cycle");
  property p_fetch_strobe_internal;
    !fetch_ext |=> o_program_fetch_strobe_n;
  endproperty
  a_fetch_strobe_internal: assert property (p_fetch_strobe_internal)
    else $error("strobe on internal fetch");
  property p_mc_length;
    mc_tick && !mode_moved_reg && !$past(mc_tick) |->
      (xtal_cnt_reg == (mode_active_reg ? 4'(DOUBLE_XTAL_PER_MC - 1)
                                        : 4'(NORMAL_XTAL_PER_MC - 1)));
  endproperty
  a_mc_length: assert property (p_mc_length) else $error("machine cycle length wrong");
  property p_mode_edge;
    $changed(mode_active_reg) |-> $past(div_reg) == 1'b0;
  endproperty
  a_mode_edge: assert property (p_mode_edge) else $error("mode changed off divider edge");
  property p_std_gap;
    o_osc_tick && !mode_active_reg |=> !o_osc_tick;
  endproperty
  a_std_gap: assert property (p_std_gap) else $error("core clock phase too short");

  property p_strap_hold;
    i_security_level1 && !block_rst && !$past(block_rst) |-> $stable(fetch_sel_eff);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("fetch select not latched");

endmodule : dscg_clock_gen

// ===== hdl/dscg_pkg.sv
package dscg_pkg;

  // ----------------------------------------------------------------
  // register map (printed offsets are word indexes)
  // ----------------------------------------------------------------
  localparam logic [7:0]  CLOCK_CONTROL_IDX   = 8'h8f;
  localparam logic [7:0]  AUX_CONTROL_IDX     = 8'h90;
  localparam logic [7:0]  CLOCK_STATUS_IDX    = 8'h91;
  localparam int          ADDR_W              = 12;
  localparam int          BYTE_SHIFT          = 2;
  localparam int          DOUBLE_SPEED_BIT    = 0;
  localparam int          ALE_DISABLE_BIT     = 0;
  localparam int          ST_MODE_BIT         = 0;
  localparam int          ST_FETCH_SEL_BIT    = 1;
  localparam int          ST_RESET_BIT        = 2;
  localparam int          ST_WDT_DRIVE_BIT    = 3;
  localparam logic        MODE_RESET_VALUE    = 1'b0;
  localparam logic        ALE_DIS_RESET_VALUE = 1'b0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          XTAL_FREQ_MHZ       = 20;
  localparam int          OSC_PER_MC          = 6;
  localparam int          NORMAL_XTAL_PER_MC  = 12;
  localparam int          DOUBLE_XTAL_PER_MC  = 6;
  localparam logic [2:0]  PHASE_LAST          = 3'h5;
  localparam logic [2:0]  ALE_PHASE_A         = 3'h0;
  localparam logic [2:0]  ALE_PHASE_B         = 3'h3;
  localparam logic [2:0]  STROBE_PHASE_A      = 3'h1;
  localparam logic [2:0]  STROBE_PHASE_B      = 3'h4;
  localparam logic [1:0]  RST_PIN_MC          = 2'h2;
  localparam logic [15:0] INTERNAL_CODE_LIMIT = 16'h3fff;

  localparam logic [1:0]  HTRANS_NONSEQ       = 2'h2;

  typedef enum logic [1:0] {
    RST_IDLE  = 2'b00,
    RST_PIN   = 2'b01,
    RST_WDT   = 2'b10
  } dscg_rst_state_type;

  typedef struct packed {
    logic        sel;
    logic        write;
    logic [7:0]  idx;
  } dscg_ahb_req_type;

endpackage : dscg_pkg

// ===== tb/dscg_ext_mem_model.sv
`timescale 1ns/1ps
module dscg_ext_mem_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_clear,
  input  wire logic        i_ale,
  input  wire logic        i_program_fetch_strobe_n,
  input  wire logic        i_fetch_external,
  output logic [15:0]      o_ale_cnt,
  output logic [15:0]      o_fetch_cnt,
  output logic [15:0]      o_stray_cnt
);
  // ------------------------------------------------------------
  // external program memory seen as strobe counters
  // ------------------------------------------------------------
  logic ale_prev_reg;
  logic strobe_prev_reg;

  always_ff @(posedge i_sys_clk) begin
    ale_prev_reg    <= i_ale;
    strobe_prev_reg <= i_program_fetch_strobe_n;
    if (i_clear) begin
      o_ale_cnt   <= 16'h0;
      o_fetch_cnt <= 16'h0;
      o_stray_cnt <= 16'h0;
    end else begin
      // ale and fetch counts take edges, not levels: a strobe lasts two cycles in standard mode
      if (i_ale && !ale_prev_reg) o_ale_cnt <= o_ale_cnt + 16'h1;
      if (!i_program_fetch_strobe_n && strobe_prev_reg) o_fetch_cnt <= o_fetch_cnt + 16'h1;
      if (!i_program_fetch_strobe_n && !i_fetch_external) o_stray_cnt <= o_stray_cnt + 16'h1;
    end
  end
endmodule : dscg_ext_mem_model

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import dscg_pkg::*;
;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam logic [31:0] CCR_ADDR = {22'h0, CLOCK_CONTROL_IDX, 2'h0};
  localparam logic [31:0] AUX_ADDR = {22'h0, AUX_CONTROL_IDX, 2'h0};
  localparam logic [31:0] STS_ADDR = {22'h0, CLOCK_STATUS_IDX, 2'h0};
  localparam int          WDT_MC   = 4;
  localparam logic [16:0] FS_TAB [4] = '{17'h00000, 17'h10000, 17'h13fff, 17'h14000};
  localparam logic        FS_EXP [4] = '{1'h1, 1'h0, 1'h0, 1'h1};

  logic        i_sys_clk, i_rst, hsel, hwrite, hready, hreadyout, hresp;
  logic        ext_rst, i_watchdog_timeout, i_external_fetch_select;
  logic        i_security_level1, i_data_access, mem_clear;
  logic        o_rst_pin_o, o_rst_pin_oe, o_internal_reset, o_osc_tick, o_core_clk;
  logic        o_machine_cycle_tick, o_ale, o_program_fetch_strobe_n, o_fetch_external;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] i_fetch_addr, ale_cnt, fetch_cnt, stray_cnt;
  wire         i_rst_pin;
  int          n_mismatch, n_checks, n;

  assign hready = hreadyout;
  // pin has a pull-down: high only when someone drives it
  assign i_rst_pin = ext_rst | (o_rst_pin_oe & o_rst_pin_o);

  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  dscg_clock_gen #(.WDT_RESET_MC(WDT_MC)) u_dscg_clock_gen (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .i_rst_pin(i_rst_pin),
    .i_watchdog_timeout(i_watchdog_timeout),
    .i_external_fetch_select(i_external_fetch_select),
    .i_security_level1(i_security_level1), .i_fetch_addr(i_fetch_addr),
    .i_data_access(i_data_access), .o_rst_pin_o(o_rst_pin_o), .o_rst_pin_oe(o_rst_pin_oe),
    .o_internal_reset(o_internal_reset), .o_osc_tick(o_osc_tick), .o_core_clk(o_core_clk),
    .o_machine_cycle_tick(o_machine_cycle_tick), .o_ale(o_ale),
    .o_program_fetch_strobe_n(o_program_fetch_strobe_n), .o_fetch_external(o_fetch_external));

  dscg_ext_mem_model u_dscg_ext_mem_model (
    .i_sys_clk(i_sys_clk), .i_clear(mem_clear), .i_ale(o_ale),
    .i_program_fetch_strobe_n(o_program_fetch_strobe_n), .i_fetch_external(o_fetch_external),
    .o_ale_cnt(ale_cnt), .o_fetch_cnt(fetch_cnt), .o_stray_cnt(stray_cnt));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge i_sys_clk);
  endtask : tick

  function automatic logic pick(input int k);
    return (k == 0) ? o_internal_reset : o_rst_pin_oe;
  endfunction : pick

  // bounded wait; running out ends the run as a failure
  task automatic await(input int k, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (pick(k) !== v) begin
      if (cnt >= lim) begin
        n_mismatch++;
        tally_and_finish();
      end
      @(posedge i_sys_clk);
      cnt++;
    end
  endtask : await

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv);
    int w;
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    w = 0;
    do begin
      @(posedge i_sys_clk);
      w++;
    end while (hready !== 1'b1 && w < 20);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge i_sys_clk);
      w++;
    end while (hready !== 1'b1 && w < 40);
    rdv = hrdata;
    chk({31'h0, hresp}, 32'h0);
    if (hready !== 1'b1) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask : ahb

  // counts over l cycles, after a settling gap
  task automatic measure(input int l, input int ea, input int ef, input int em, input int eo);
    int m;
    int o;
    m = 0;
    o = 0;
    tick(24);
    mem_clear <= 1'b1;
    tick(1);
    mem_clear <= 1'b0;
    repeat (l) begin
      @(posedge i_sys_clk);
      m += int'(o_machine_cycle_tick === 1'b1);
      o += int'(o_osc_tick === 1'b1 && o_core_clk === 1'b1);
    end
    #1;
    chk({16'h0, ale_cnt}, ea);
    chk({16'h0, fetch_cnt}, ef);
    chk({16'h0, stray_cnt}, 32'h0);
    chk(m, em);
    chk(o, eo);
    tick(1);
  endtask : measure

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    {hsel, hwrite, ext_rst, i_watchdog_timeout, i_data_access} = 5'h0;
    {i_external_fetch_select, i_security_level1, mem_clear} = 3'h0;
    {haddr, hwdata, i_fetch_addr} = 80'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    i_rst = 1'b1;
    n_mismatch = 0;
    n_checks = 0;
    tick(4);
    i_rst <= 1'b0;
    tick(1);
    ahb(1'h0, CCR_ADDR, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(1'h0, AUX_ADDR, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(1'h1, 32'h0, 32'hffffffff, rd);
    ahb(1'h0, 32'h0, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(1'h0, STS_ADDR, 32'h0, rd);
    chk(rd, 32'h0);
    measure(120, 20, 20, 10, 60);
    $display("test reset_and_standard done");
    ahb(1'h1, CCR_ADDR, 32'h1, rd);
    ahb(1'h0, CCR_ADDR, 32'h0, rd);
    chk(rd, 32'h1);
    ahb(1'h0, STS_ADDR, 32'h0, rd);
    chk(rd, 32'h1);
    measure(120, 40, 40, 20, 120);
    ahb(1'h1, CCR_ADDR, 32'h0, rd);
    measure(120, 20, 20, 10, 60);
    $display("test double_speed done");
    i_data_access <= 1'b1;
    measure(120, 10, 0, 10, 60);
    i_data_access <= 1'b0;
    $display("test data_access done");
    for (int k = 0; k < 4; k++) begin
      {i_external_fetch_select, i_fetch_addr} <= FS_TAB[k];
      tick(2);
      chk(32'(o_fetch_external), 32'(FS_EXP[k]));
    end
    ahb(1'h1, AUX_ADDR, 32'h1, rd);
    measure(120, 20, 20, 10, 60);
    i_fetch_addr <= 16'h0;
    measure(120, 0, 0, 10, 60);
    ahb(1'h1, AUX_ADDR, 32'h0, rd);
    measure(120, 20, 0, 10, 60);
    $display("test fetch_select done");
    i_security_level1 <= 1'b1;
    i_rst <= 1'b1;
    tick(4);
    i_rst <= 1'b0;
    i_external_fetch_select <= 1'b0;
    tick(3);
    chk(32'(o_fetch_external), 32'h0);
    ahb(1'h0, STS_ADDR, 32'h0, rd);
    chk(rd, 32'h2);
    i_security_level1 <= 1'b0;
    i_rst <= 1'b1;
    tick(4);
    i_rst <= 1'b0;
    tick(1);
    $display("test security done");
    ahb(1'h1, CCR_ADDR, 32'h1, rd);
    tick(24);
    ext_rst <= 1'b1;
    await(0, 1'b1, 40, n);
    chk(32'(n >= 12 && n <= 20), 32'h1);
    tick(2);
    chk(32'({o_ale, o_program_fetch_strobe_n}), 32'h1);
    ext_rst <= 1'b0;
    await(0, 1'b0, 4, n);
    ahb(1'h0, CCR_ADDR, 32'h0, rd);
    chk(rd, 32'h0);
    $display("test pin_reset done");
    i_watchdog_timeout <= 1'b1;
    tick(1);
    i_watchdog_timeout <= 1'b0;
    await(1, 1'b1, 4, n);
    n = 0;
    while (o_rst_pin_oe === 1'b1 && n < 200) begin
      chk(32'({o_internal_reset, o_rst_pin_o}), 32'h3);
      tick(1);
      n++;
    end
    chk(32'(n >= 36 && n <= 60), 32'h1);
    await(0, 1'b0, 20, n);
    $display("test watchdog done");
    tally_and_finish();
  end
endmodule : tb_top
